// File: core/tlis_map.svh
// Constants of the tunable module two-wire slave: timing and strap values.
// Assumes a 250 MHz system clock; included by the core, the checker and the bench.
`ifndef TLIS_MAP_SVH
`define TLIS_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define TLIS_CLK_MHZ        250
`define TLIS_GLITCH_NS      16
`define TLIS_GLITCH_CYC     ((`TLIS_GLITCH_NS * `TLIS_CLK_MHZ) / 1000)
`define TLIS_STRAP_CYC      2'h2

// ----------------------------------------------------------------------
// Frame layout and reset values
// ----------------------------------------------------------------------
`define TLIS_BITS_PER_BYTE  4'h8
`define TLIS_PKT_BYTES      3'h4
`define TLIS_FILL_BYTE      8'hff
`define TLIS_CAP_RATE       3'h0

`endif

// File: core/tlis_pkg.sv
// Types shared by the tunable module two-wire slave.
// Includes nothing; tlis_map.svh is included by the core, the checker and the bench.
package tlis_pkg;

    typedef enum logic [2:0] {
        TLIS_IDLE,
        TLIS_ADDR,
        TLIS_ADDR_ACK,
        TLIS_RX,
        TLIS_RX_ACK,
        TLIS_TX,
        TLIS_TX_ACK
    } tlis_state_t;

    // Four-byte packet; byte 0 is the first byte on the wire.
    typedef logic [3:0][7:0] tlis_pkt_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } tlis_line_t;

endpackage : tlis_pkg

// File: core/tlis_i2c_slave.sv
// Two-wire slave core of a tunable module: framing of 4-byte packets.
// Assumes open-drain pads outside; the pad drives low while an enable is
// high. Command logic on clk_sys takes cmd_data and answers by rsp_load.
`timescale 1ns/100ps
`include "tlis_map.svh"

// Summary of operation
// (RL1) Slave only; the host starts, clocks and ends every transfer.
// (RL2) SDA changes only while SCL is low, stable while SCL high.
// (RL3) START is SDA falling while SCL is high.
// (RL4) STOP is SDA rising while SCL is high.
// (RL5) Only the host generates START and STOP.
// (RL6) Bus busy from START to STOP; repeated START acts like START.
// (RL7) Bytes are eight bits, MSB first, followed by an acknowledge bit.
// (RL8) Command and response packets are exactly four bytes.
// (RL9) Any SCL hold-low between bytes ends within one 9-bit byte time.
// (RL10) Host pauses no longer than one 9-bit byte time between bytes.
// (RL11) Clock stretching is avoided where possible.
// (RL12) Execution shown on command_busy_n, never by holding SCL.
// (RL13) Host learns completion from command_busy_n or by polling.
// (RL14) Master clocks acknowledge; transmitter releases SDA during it.
// (RL15) Receiver holds SDA low for the whole acknowledge high period.
// (RL16) Addressed as receiver, the module acknowledges each byte.
// (RL17) Cannot respond to its address: SDA left high at address ack.
// (RL18) Cannot accept more data: the next byte is not acknowledged.
// (RL19) Host nacks last read byte; module then releases SDA.
// (RL20) Standard rate supported; maximum rate declared in capability.
// (RL21) Lines driven only low or released; both high means idle.
// (RL22) 7-bit address: fixed class prefix, low bits from select pins.
// (RL23) Bit after the address: zero host writes, one host reads.
// (RL24) Host writes command packets and reads responses later.
// (RL25) command_busy_n low while executing and response not ready.
// (RL26) SCL and SDA synchronised and glitch filtered before decoding.
module tlis_i2c_slave
    import tlis_pkg::*;
#(
    // Class prefix of the slave address; value is arbitrary.
    parameter logic [3:0] ADDR_CLASS = 4'h5
) (
    input  wire logic      clk_sys,
    input  wire logic      reset,
    input  wire logic      scl_i,
    output logic           scl_o,
    output logic           scl_oe,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe,
    input  wire logic      address_select_bit0,
    input  wire logic      address_select_bit1,
    input  wire logic      address_select_bit2,
    input  wire logic      module_select_n,
    output logic           command_busy_n,
    output logic [2:0]     interface_capability,
    output tlis_pkt_t      cmd_data,
    output logic           cmd_valid,
    input  wire tlis_pkt_t rsp_data,
    input  wire logic      rsp_load
);

    localparam int         FILT_CYC = `TLIS_GLITCH_CYC;
    localparam logic [2:0] FILT_MAX = 3'(FILT_CYC);

    // ------------------------------------------------------------------
    // Pin synchronisers and glitch filters
    // ------------------------------------------------------------------
    tlis_line_t line_raw;
    tlis_line_t line_s1_reg;
    tlis_line_t line_s2_reg;
    tlis_line_t line_f_reg;
    tlis_line_t line_p_reg;
    logic [1:0][2:0] filt_cnt_reg;

    assign line_raw = '{scl: scl_i, sda: sda_i};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_s1_reg <= '{scl: 1'b1, sda: 1'b1};
            line_s2_reg <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            line_s1_reg <= line_raw;
            line_s2_reg <= line_s1_reg;
        end
    end

    // A change must persist FILT_CYC cycles before it is believed.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    filt_cnt_reg[gi] <= 3'h0;
                    line_f_reg[gi]   <= 1'b1;
                end else if (line_s2_reg[gi] == line_f_reg[gi]) begin
                    filt_cnt_reg[gi] <= 3'h0;
                end else if (filt_cnt_reg[gi] == FILT_MAX - 3'h1) begin
                    filt_cnt_reg[gi] <= 3'h0;
                    line_f_reg[gi]   <= line_s2_reg[gi];  // [RL26]
                end else begin
                    filt_cnt_reg[gi] <= filt_cnt_reg[gi] + 3'h1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_p_reg <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            line_p_reg <= line_f_reg;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = line_f_reg.scl & ~line_p_reg.scl;
    assign scl_fall = ~line_f_reg.scl & line_p_reg.scl;
    // SCL stays high across a condition, so SCL high is checked
    // on the previous and the current sample.
    assign start_det = line_f_reg.scl & line_p_reg.scl &
                       line_p_reg.sda & ~line_f_reg.sda;  // [RL3]
    assign stop_det  = line_f_reg.scl & line_p_reg.scl &
                       ~line_p_reg.sda & line_f_reg.sda;  // [RL4]

    // ------------------------------------------------------------------
    // Address straps and module select
    // ------------------------------------------------------------------
    logic [2:0] strap_s1_reg;
    logic [2:0] strap_s2_reg;
    logic [2:0] addr_low_reg;
    logic [1:0] strap_cnt_reg;
    logic       ms_s1_reg;
    logic       ms_s2_reg;
    logic       ms_p_reg;
    logic       ms_rise;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
        end else begin
            strap_s1_reg <= {address_select_bit2, address_select_bit1,
                             address_select_bit0};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // The straps are caught once, when the synchroniser has filled
    // after reset release; later pin changes are ignored.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strap_cnt_reg <= 2'h0;
            addr_low_reg  <= 3'h0;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == `TLIS_STRAP_CYC) begin
                addr_low_reg <= strap_s2_reg;  // [RL22]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ms_s1_reg <= 1'b1;
            ms_s2_reg <= 1'b1;
            ms_p_reg  <= 1'b1;
        end else begin
            ms_s1_reg <= module_select_n;
            ms_s2_reg <= ms_s1_reg;
            ms_p_reg  <= ms_s2_reg;
        end
    end

    assign ms_rise = ms_s2_reg & ~ms_p_reg;

    // ------------------------------------------------------------------
    // Byte and packet engine
    // ------------------------------------------------------------------
    tlis_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic [3:0]  bit_cnt_reg;
    logic [2:0]  byte_cnt_reg;
    logic        read_reg;
    logic        wr_txn_reg;
    tlis_pkt_t   rx_buf_reg;
    tlis_pkt_t   rsp_reg;
    logic        addr_hit;
    logic        pkt_done;
    logic [7:0]  next_tx;

    assign addr_hit = (shift_reg[7:1] == {ADDR_CLASS, addr_low_reg});
    // A packet is complete only with exactly four bytes when the host
    // ends the transfer by STOP or repeated START.
    assign pkt_done = (start_det | stop_det) & wr_txn_reg &
                      (byte_cnt_reg == `TLIS_PKT_BYTES);  // [RL8] [RL6]
    assign next_tx  = (byte_cnt_reg < `TLIS_PKT_BYTES) ?
                      rsp_reg[byte_cnt_reg[1:0]] : `TLIS_FILL_BYTE;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg    <= TLIS_IDLE;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            bit_cnt_reg  <= 4'h0;
            byte_cnt_reg <= 3'h0;
            read_reg     <= 1'b0;
            wr_txn_reg   <= 1'b0;
            rx_buf_reg   <= '0;
            sda_oe       <= 1'b0;
        end else if (ms_rise || stop_det) begin
            state_reg  <= TLIS_IDLE;  // [RL21]
            wr_txn_reg <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (start_det) begin
            state_reg    <= TLIS_ADDR;  // [RL6]
            bit_cnt_reg  <= 4'h0;
            byte_cnt_reg <= 3'h0;
            wr_txn_reg   <= 1'b0;
            sda_oe       <= 1'b0;
        end else begin
            unique case (state_reg)
                TLIS_IDLE: begin
                    sda_oe <= 1'b0;  // [RL1]
                end
                TLIS_ADDR, TLIS_RX: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], line_f_reg.sda};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;  // [RL7]
                    end else if (scl_fall &&
                                 bit_cnt_reg == `TLIS_BITS_PER_BYTE) begin
                        if (state_reg == TLIS_ADDR) begin
                            // Busy means no room for a command and no
                            // response yet, so the address is declined.
                            if (addr_hit && command_busy_n) begin
                                read_reg  <= shift_reg[0];  // [RL23]
                                sda_oe    <= 1'b1;  // [RL15]
                                state_reg <= TLIS_ADDR_ACK;
                            end else begin
                                state_reg <= TLIS_IDLE;  // [RL17]
                            end
                        end else if (byte_cnt_reg < `TLIS_PKT_BYTES) begin
                            rx_buf_reg[byte_cnt_reg[1:0]] <= shift_reg;
                            byte_cnt_reg <= byte_cnt_reg + 3'h1;
                            sda_oe       <= 1'b1;  // [RL16]
                            state_reg    <= TLIS_RX_ACK;
                        end else begin
                            wr_txn_reg <= 1'b0;  // [RL18]
                            state_reg  <= TLIS_IDLE;
                        end
                    end
                end
                TLIS_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (read_reg) begin
                            tx_reg       <= rsp_reg[0];
                            sda_oe       <= ~rsp_reg[0][7];  // [RL2]
                            byte_cnt_reg <= 3'h1;
                            state_reg    <= TLIS_TX;
                        end else begin
                            sda_oe     <= 1'b0;
                            wr_txn_reg <= 1'b1;  // [RL24]
                            state_reg  <= TLIS_RX;
                        end
                    end
                end
                TLIS_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe      <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= TLIS_RX;
                    end
                end
                TLIS_TX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == `TLIS_BITS_PER_BYTE) begin
                            sda_oe    <= 1'b0;  // [RL14]
                            state_reg <= TLIS_TX_ACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b1};
                            sda_oe <= ~tx_reg[6];  // [RL7] [RL2]
                        end
                    end
                end
                TLIS_TX_ACK: begin
                    if (scl_rise && line_f_reg.sda) begin
                        state_reg <= TLIS_IDLE;  // [RL19]
                    end else if (scl_fall) begin
                        tx_reg       <= next_tx;
                        sda_oe       <= ~next_tx[7];
                        bit_cnt_reg  <= 4'h0;
                        byte_cnt_reg <= (byte_cnt_reg == 3'h7) ?
                                        byte_cnt_reg : byte_cnt_reg + 3'h1;
                        state_reg    <= TLIS_TX;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command hand-off, response and busy indication
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cmd_valid <= 1'b0;
            cmd_data  <= '0;
        end else begin
            cmd_valid <= pkt_done;
            if (pkt_done) begin
                cmd_data <= rx_buf_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rsp_reg <= '0;
        end else if (rsp_load) begin
            rsp_reg <= rsp_data;
        end
    end

    // A new command wins over a response load in the same cycle.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            command_busy_n <= 1'b1;
        end else if (pkt_done) begin
            command_busy_n <= 1'b0;  // [RL12] [RL25]
        end else if (rsp_load) begin
            command_busy_n <= 1'b1;  // [RL25]
        end
    end

    // ------------------------------------------------------------------
    // Constant drives
    // ------------------------------------------------------------------
    // SCL is never held: every byte is taken or answered from registers
    // in the same bit time, which trades latency for zero wait states.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            scl_o                <= 1'b0;
            scl_oe               <= 1'b0;
            sda_o                <= 1'b0;
            interface_capability <= `TLIS_CAP_RATE;
        end else begin
            scl_o                <= 1'b0;
            scl_oe               <= 1'b0;  // [RL11] [RL9]
            sda_o                <= 1'b0;  // [RL21]
            interface_capability <= `TLIS_CAP_RATE;  // [RL20]
        end
    end

endmodule : tlis_i2c_slave

// File: tb/tlis_i2c_slave_properties.sv
// Port-level timing relations of the two-wire slave core.
// Assumes it is bound to every tlis_i2c_slave instance.
`timescale 1ns/100ps
`include "tlis_map.svh"
module tlis_i2c_slave_properties
    import tlis_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      reset,
    input wire logic      scl_i,
    input wire logic      scl_o,
    input wire logic      scl_oe,
    input wire logic      sda_i,
    input wire logic      sda_o,
    input wire logic      sda_oe,
    input wire logic      command_busy_n,
    input wire logic [2:0] interface_capability,
    input wire tlis_pkt_t cmd_data,
    input wire logic      cmd_valid,
    input wire logic      rsp_load
);
    // ------------------------------------------------------------------
    // Relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    sequence s_done;
        cmd_valid ##1 !cmd_valid;
    endsequence

    property p_scl_free;
        !scl_oe && !scl_o;
    endproperty
    property p_low_only;
        sda_oe |-> !sda_o;
    endproperty
    property p_cap;
        interface_capability == `TLIS_CAP_RATE;
    endproperty
    // Data may only move while the clock pin is low.
    property p_sda_steady;
        (scl_i && $past(scl_i)) |-> $stable(sda_oe);
    endproperty
    property p_stop_idle;
        s_stop |-> !sda_oe [*8];
    endproperty
    property p_valid_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    property p_pkt_busy;
        s_done |-> !command_busy_n;
    endproperty
    property p_busy_hold;
        (!command_busy_n && !rsp_load) |=> !command_busy_n;
    endproperty
    // A packet that ends in the load cycle shows its strobe next cycle
    // and keeps busy low, since a new command wins over the load.
    property p_busy_clear;
        (rsp_load && !cmd_valid) |=> (command_busy_n || cmd_valid);
    endproperty
    property p_busy_cause;
        $fell(command_busy_n) |-> (cmd_valid || $past(cmd_valid));
    endproperty
    property p_cmd_hold;
        $changed(cmd_data) |-> ##[0:1] (cmd_valid || $past(cmd_valid));
    endproperty

    a_scl_free: assert property (p_scl_free)
        else $error("clock line pulled by slave");
    a_low_only: assert property (p_low_only)
        else $error("data line driven high");
    a_cap: assert property (p_cap)
        else $error("capability code wrong");
    a_sda_steady: assert property (p_sda_steady)
        else $error("data changed while clock high");
    a_stop_idle: assert property (p_stop_idle)
        else $error("data driven after stop");
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("packet strobe longer than one cycle");
    a_pkt_busy: assert property (p_pkt_busy)
        else $error("busy not shown after packet");
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped before response");
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy kept after response load");
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy raised without packet");
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command data changed without packet");
endmodule : tlis_i2c_slave_properties

bind tlis_i2c_slave tlis_i2c_slave_properties chk_u (
    .clk_sys(clk_sys), .reset(reset), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .command_busy_n(command_busy_n),
    .interface_capability(interface_capability), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .rsp_load(rsp_load)
);

// File: tb/tlis_host_model.sv
// Host model: the bus master that starts, clocks and ends every transfer.
// Assumes the bench resolves both wires from all pull-down enables.
`timescale 1ns/100ps
module tlis_host_model (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    // ------------------------------------------------------------------
    // Bit timing: one step is a quarter of the 160 ns bus period
    // ------------------------------------------------------------------
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic step(input logic c, input logic d);
        scl_low = c;
        sda_low = d;
        repeat (10) @(negedge clk_sys);
    endtask : step
    // Entered with the clock low this also serves as a repeated start.
    task automatic start();
        step(scl_low, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask : start
    task automatic stop();
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        step(1'b1, !b);
        step(1'b0, !b);
        r = sda_line;
        step(1'b0, !b);
        step(1'b1, !b);
    endtask : bit_x
    // Bytes follow each other at once, well inside the pause limit.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, ack);
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : rbyte
endmodule : tlis_host_model

// File: tb/tb.sv
// Self-checking bench of the two-wire slave core against a host model.
// Assumes core, package, checker and host model are compiled first.
`timescale 1ns/100ps
`include "tlis_map.svh"
module tb;
    import tlis_pkg::*;
    // ------------------------------------------------------------------
    // Wiring, host and checks
    // ------------------------------------------------------------------
    localparam logic [3:0] CLASS = 4'h5; // Arbitrary class prefix.
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic       module_select_n = 1'b0;
    logic       rsp_load = 1'b0;
    logic [2:0] strap = 3'h0;
    tlis_pkt_t  rsp_data = '0;
    logic       scl_low, sda_low, scl_o, scl_oe, sda_o, sda_oe, k;
    logic       command_busy_n, cmd_valid;
    logic [2:0] interface_capability;
    tlis_pkt_t  cmd_data, pk;
    tlis_pkt_t  exp_q[$];
    logic [7:0] addr;
    int         seed = 44753;
    int         err_total = 0;
    int         check_count = 0;
    int         cyc = 0;
    wire        scl_line = ~(scl_low | scl_oe);
    wire        sda_line = ~(sda_low | sda_oe);

    tlis_i2c_slave #(.ADDR_CLASS(CLASS)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .scl_i(scl_line), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_select_bit0(strap[0]), .address_select_bit1(strap[1]),
        .address_select_bit2(strap[2]), .module_select_n(module_select_n),
        .command_busy_n(command_busy_n),
        .interface_capability(interface_capability), .cmd_data(cmd_data),
        .cmd_valid(cmd_valid), .rsp_data(rsp_data), .rsp_load(rsp_load)
    );
    tlis_host_model host_u (.clk_sys(clk_sys), .sda_line(sda_line),
        .scl_low(scl_low), .sda_low(sda_low));

    initial forever #2 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        if (cmd_valid === 1'b1) begin
            if (exp_q.size() == 0) check("cmd_valid", 0, 1);
            else check("cmd_data", exp_q.pop_front(), cmd_data);
        end
    end
    // The whole run needs about 13000 cycles.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end

    task automatic xfer(input logic [7:0] a, input int n, input logic na,
                        output tlis_pkt_t p);
        logic [7:0] d;
        host_u.start();
        host_u.wbyte(a, k);
        check("addr_ack", na, k);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            if (i < 4) p[i] = d;
            host_u.wbyte(d, k);
            check("data_ack", i > 3, k);
        end
    endtask : xfer
    task automatic rd(input int n);
        logic [7:0] d;
        logic [7:0] e;
        host_u.start();
        host_u.wbyte({addr[7:1], 1'b1}, k);
        check("read_ack", 0, k);
        for (int i = 0; i < n; i++) begin
            host_u.rbyte(i == n - 1, d);
            e = (i < 4) ? rsp_data[i] : `TLIS_FILL_BYTE;
            check("read_byte", e, d);
        end
        host_u.stop();
    endtask : rd
    task automatic wait_busy();
        for (int i = 0; i < 100 && command_busy_n !== 1'b0; i++)
            @(negedge clk_sys);
        check("busy_set", 0, command_busy_n);
    endtask : wait_busy
    task automatic load();
        rsp_data = $random(seed);
        rsp_load = 1'b1;
        @(negedge clk_sys);
        rsp_load = 1'b0;
        @(negedge clk_sys);
        check("busy_clear", 1, command_busy_n);
    endtask : load

    initial begin
        strap = 3'($random(seed));
        addr = {CLASS, strap, 1'b0};
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        repeat (12) @(negedge clk_sys);
        check("capability", `TLIS_CAP_RATE, interface_capability);
        xfer(addr, 4, 1'b0, pk);
        exp_q.push_back(pk);
        host_u.stop();
        wait_busy();
        $display("test write done");
        xfer(addr, 0, 1'b1, pk);
        xfer(addr | 8'h01, 0, 1'b1, pk);
        host_u.stop();
        $display("test busy refusal done");
        load();
        rd(5);
        $display("test read done");
        xfer(addr ^ 8'h02, 0, 1'b1, pk);
        host_u.stop();
        xfer(addr, 5, 1'b0, pk);
        host_u.stop();
        repeat (40) @(negedge clk_sys);
        check("busy_idle", 1, command_busy_n);
        $display("test refusal done");
        xfer(addr, 2, 1'b0, pk);
        xfer(addr, 4, 1'b0, pk);
        exp_q.push_back(pk);
        // A packet ended by a repeated start makes the next address
        // arrive while busy, so it is declined.
        xfer(addr | 8'h01, 0, 1'b1, pk);
        host_u.stop();
        wait_busy();
        load();
        $display("test repeated start done");
        xfer(addr, 2, 1'b0, pk);
        module_select_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        module_select_n = 1'b0;
        for (int i = 0; i < 2; i++) begin
            host_u.wbyte(8'h3c, k);
            check("abort_ack", 1, k);
        end
        host_u.stop();
        repeat (40) @(negedge clk_sys);
        check("pending", 0, exp_q.size());
        $display("test abort done");
        results();
    end
endmodule : tb
